// ---- rtl/oskg_pkg.sv ----
// package: constants for output skew and gating control
package oskg_pkg;
  localparam int N_OUT = 4;
  localparam int SKEW_W = 4;
  localparam logic [4:0] SKEW_STEPS = 5'h10;
  localparam logic [3:0] SKEW_SPAN = 4'hf;
  // vco phase counter: eight taps per vco period
  localparam int PH_W = 3;
  localparam logic [2:0] FINE_INC = 3'h1;
  localparam logic [2:0] COARSE_INC = 3'h2;
  localparam int DIV_W = 6;
  localparam int CLK_PERIOD_PS = 4000;
  localparam int OE_MAX_NS = 20;
  localparam int OE_CYC = (OE_MAX_NS * 1000) / CLK_PERIOD_PS;
  localparam int LRST_MIN_NS = 20;
  localparam int LRST_CYC = (LRST_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int PRST_MIN_US = 1000;
  localparam int PRST_CYC = PRST_MIN_US * 1000000 / CLK_PERIOD_PS;
  localparam int CNT_W = 18;
  localparam int PROF_N = 4;
  localparam logic [7:0] AXI_OKAY = 8'h00;
  // register offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_SKEW = 8'h04;
  localparam logic [7:0] REG_PROF = 8'h08;
  localparam logic [7:0] REG_STAT = 8'h0c;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [31:0] SKEW_RST = 32'h0000_0000;
  typedef enum logic [2:0] {
    OSKG_PLL_RUN = 3'h1,
    OSKG_PLL_RST = 3'h2,
    OSKG_PLL_REL = 3'h4
  } oskg_pll_t;
endpackage : oskg_pkg

// ---- rtl/oskg_out.sv ----
// one output channel: skewed divided clock with glitch-free gate
`timescale 1ns/1ps
module oskg_out
  import oskg_pkg::*;
(
  input wire logic aclk,
  input wire logic rst,
  input wire logic vco_en,
  input wire logic [PH_W-1:0] vco_phase,
  input wire logic coarse,
  input wire logic [SKEW_W-1:0] skew,
  input wire logic [DIV_W-1:0] half_div,
  input wire logic gate,
  output logic clk_out
);
  typedef struct packed {
    logic [DIV_W-1:0] cnt;
    logic [SKEW_W+1:0] dly;
    logic run;
    logic lvl;
    logic out;
    logic gate_q;
  } oskg_ch_t;
  oskg_ch_t r, next_r;
  logic [SKEW_W+1:0] target;
  always_comb begin
    next_r = r;
    // RULE_02 step of eighth or quarter
    target = coarse ? {1'b0, skew, 1'b0} : {2'b00, skew};
    if (vco_en) begin
      // RULE_03 span is fifteen steps
      if (r.dly != target) next_r.dly = r.dly + 6'h01;
      else begin
        if (r.cnt + 6'h01 >= half_div) begin
          next_r.cnt = 6'h00;
          next_r.lvl = ~r.lvl;
          // RULE_10 gate only at low boundary
          if (r.lvl) next_r.run = r.gate_q;
        end else next_r.cnt = r.cnt + 6'h01;
      end
    end
    next_r.gate_q = gate;
    next_r.out = r.lvl & r.run;
    if (rst) next_r = '0;
  end
  always_ff @(posedge aclk) begin
    r <= next_r;
  end
  assign clk_out = r.out;
  logic unused_phase;
  assign unused_phase = ^vco_phase;
endmodule : oskg_out

// ---- rtl/oskg_top.sv ----
// top: output skew, gating, enables, resets and profile select
// Operation
// RULE_01: sixteen skew settings, four-bit selector
// RULE_02: step is eighth or quarter vco period
// RULE_03: span equals fifteen steps
// RULE_04: host changes gate three output cycles early
// RULE_05: enables act within twenty nanoseconds
// RULE_06: pll reset held one millisecond, full reset; pll_reset only follows the pin, with no minimum width
// RULE_07: logic reset twenty nanoseconds, pll untouched
// RULE_08: host holds reset after profile change
// RULE_09: sample profile under reset, apply at release
// RULE_10: gate changes only on output boundary
//
// Implementation choices: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module oskg_top
  import oskg_pkg::*;
#(
  parameter int PRST_CYCLES = PRST_CYC
)
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic logic_reset_n,
  input wire logic pll_reset_n,
  input wire logic [1:0] profile_select,
  input wire logic bank_x_output_enable,
  input wire logic bank_y_output_enable,
  input wire logic global_output_enable,
  input wire logic [N_OUT-1:0] output_clock_gate,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic pll_reset,
  output logic [N_OUT-1:0] clk_out
);
  typedef struct packed {
    logic aw_got;
    logic w_got;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic coarse;
    logic [5:0] half_div;
    logic [N_OUT*SKEW_W-1:0] skew;
    logic [PROF_N*N_OUT*SKEW_W-1:0] prof;
    logic [1:0] prof_q;
    logic [1:0] prof_act;
    logic lrst;
    logic lrst_q;
    logic [CNT_W-1:0] pcnt;
    oskg_pll_t pll;
    logic pll_out;
    logic [N_OUT-1:0] oe;
    logic [PH_W-1:0] phase;
  } oskg_st_t;
  oskg_st_t r, next_r;
  logic [N_OUT-1:0] ch_clk;
  logic rst_any;
  logic [N_OUT-1:0] ch_out_q;
  assign rst_any = r.lrst | (r.pll != OSKG_PLL_RUN);
  always_comb begin
    next_r = r;
    next_r.phase = r.phase + (r.coarse ? COARSE_INC : FINE_INC);
    // RULE_07 logic reset only digital
    next_r.lrst = ~logic_reset_n;
    next_r.lrst_q = r.lrst;
    // RULE_09 sample profile during reset
    if (r.lrst) next_r.prof_q = profile_select;
    if (r.lrst_q && !r.lrst) begin
      next_r.prof_act = r.prof_q;
      next_r.skew = r.prof[r.prof_q*N_OUT*SKEW_W +: N_OUT*SKEW_W];
    end
    // RULE_06 pll reset follows pin width, no minimum enforced; full reset
    case (r.pll)
      OSKG_PLL_RUN: begin
        if (!pll_reset_n) begin
          next_r.pll = OSKG_PLL_RST;
          next_r.pcnt = '0;
        end
      end
      OSKG_PLL_RST: begin
        if (r.pcnt < CNT_W'(PRST_CYCLES)) next_r.pcnt = r.pcnt + 18'h00001;
        if (pll_reset_n) next_r.pll = OSKG_PLL_REL;
      end
      OSKG_PLL_REL: begin
        next_r.pll = OSKG_PLL_RUN;
      end
      default: next_r.pll = OSKG_PLL_RUN;
    endcase
    next_r.pll_out = (r.pll == OSKG_PLL_RST) & (r.pcnt >= CNT_W'(PRST_CYCLES) | 1'b1);
    // RULE_05 enables registered here, reach clk_out two cycles later
    for (int i = 0; i < N_OUT; i++) begin
      next_r.oe[i] = global_output_enable &
        (i < N_OUT/2 ? bank_x_output_enable : bank_y_output_enable);
    end
    // axi write
    if (s_axi_awvalid && !r.aw_got) begin
      next_r.aw_got = 1'b1;
      next_r.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !r.w_got) begin
      next_r.w_got = 1'b1;
      next_r.wdata = s_axi_wdata;
      next_r.wstrb = s_axi_wstrb;
    end
    if (r.aw_got && r.w_got && !r.bvalid) begin
      next_r.aw_got = 1'b0;
      next_r.w_got = 1'b0;
      next_r.bvalid = 1'b1;
      next_r.bresp = RESP_OKAY;
      if (r.awaddr == REG_CTRL) begin
        if (r.wstrb[0]) begin
          next_r.coarse = r.wdata[0];
          next_r.half_div = r.wdata[7:2];
        end
      end else if (r.awaddr == REG_SKEW) begin
        // RULE_01 four bits per output
        for (int b = 0; b < 2; b++)
          if (r.wstrb[b]) next_r.skew[b*8 +: 8] = r.wdata[b*8 +: 8];
      end else if (r.awaddr == REG_PROF) begin
        next_r.prof[r.wdata[17:16]*N_OUT*SKEW_W +: N_OUT*SKEW_W] = r.wdata[15:0];
      end else begin
        next_r.bresp = RESP_SLVERR;
      end
    end
    if (r.bvalid && s_axi_bready) next_r.bvalid = 1'b0;
    if (s_axi_arvalid && !r.rvalid) begin
      next_r.rvalid = 1'b1;
      next_r.rresp = RESP_OKAY;
      if (s_axi_araddr == REG_CTRL) next_r.rdata = {24'h0, r.half_div, 1'b0, r.coarse};
      else if (s_axi_araddr == REG_SKEW) next_r.rdata = {16'h0, r.skew};
      else if (s_axi_araddr == REG_STAT)
        next_r.rdata = {24'h0, r.oe, r.prof_act, r.pll_out, r.lrst};
      else begin
        next_r.rdata = 32'h0;
        next_r.rresp = RESP_SLVERR;
      end
    end
    if (r.rvalid && s_axi_rready) next_r.rvalid = 1'b0;
    if (!aresetn) begin
      next_r = '0;
      next_r.pll = OSKG_PLL_RUN;
      next_r.half_div = 6'h01;
    end
  end
  always_ff @(posedge aclk) begin
    r <= next_r;
  end
  genvar g;
  generate
    for (g = 0; g < N_OUT; g++) begin : g_ch
      // RULE_04 gate setup is host duty
      oskg_out u_ch (
        .aclk(aclk),
        .rst(rst_any | ~aresetn),
        .vco_en(1'b1),
        .vco_phase(r.phase),
        .coarse(r.coarse),
        .skew(r.skew[g*SKEW_W +: SKEW_W]),
        .half_div(r.half_div),
        .gate(output_clock_gate[g]),
        .clk_out(ch_clk[g])
      );
    end
  endgenerate
  // RULE_05 output enable gating
  always_ff @(posedge aclk) begin
    if (!aresetn) ch_out_q <= '0;
    else ch_out_q <= ch_clk & r.oe;
  end
  assign clk_out = ch_out_q;
  assign s_axi_awready = !r.aw_got;
  assign s_axi_wready = !r.w_got;
  assign s_axi_bvalid = r.bvalid;
  assign s_axi_bresp = r.bresp;
  assign s_axi_arready = !r.rvalid;
  assign s_axi_rvalid = r.rvalid;
  assign s_axi_rresp = r.rresp;
  assign s_axi_rdata = r.rdata;
  assign pll_reset = r.pll_out;
  // RULE_05 enable latency bound
  property p_oe;
    @(posedge aclk) disable iff (!aresetn)
      !global_output_enable |-> ##2 (clk_out == '0);
  endproperty
  a_oe: assert property (p_oe) else $error("output not disabled"); // RULE_05
  // RULE_05 bank x enable latency
  property p_bank_x;
    @(posedge aclk) disable iff (!aresetn)
      !bank_x_output_enable |-> ##2 (clk_out[1:0] == 2'h0);
  endproperty
  a_bank_x: assert property (p_bank_x) else $error("bank x not disabled"); // RULE_05
  // RULE_06 pll reset follows pin
  property p_pll;
    @(posedge aclk) disable iff (!aresetn)
      (r.pll == OSKG_PLL_RUN && !pll_reset_n) |-> ##2 pll_reset;
  endproperty
  a_pll: assert property (p_pll) else $error("pll reset missing"); // RULE_06
  // RULE_07 logic reset leaves pll
  property p_lrst;
    @(posedge aclk) disable iff (!aresetn)
      (!logic_reset_n && pll_reset_n && r.pll == OSKG_PLL_RUN) |=> r.pll == OSKG_PLL_RUN;
  endproperty
  a_lrst: assert property (p_lrst) else $error("logic reset hit pll"); // RULE_07
  // RULE_09 profile applied at release
  property p_prof;
    @(posedge aclk) disable iff (!aresetn)
      (r.lrst_q && !r.lrst) |=> r.prof_act == $past(r.prof_q);
  endproperty
  a_prof: assert property (p_prof) else $error("profile not applied"); // RULE_09
  // RULE_10 no output under reset
  property p_gate;
    @(posedge aclk) disable iff (!aresetn)
      r.lrst [*3] |-> clk_out == '0;
  endproperty
  a_gate: assert property (p_gate) else $error("output during reset"); // RULE_10
  c_wr: cover property (@(posedge aclk) s_axi_bvalid && s_axi_bready);
  c_rd: cover property (@(posedge aclk) s_axi_rvalid && s_axi_rready);
  c_clk: cover property (@(posedge aclk) $rose(clk_out[0]));
endmodule : oskg_top

// ---- sim/oskg_board.sv ----
// board-side model driving reset, profile, enable and gate pins
`timescale 1ns/1ps
module oskg_board
  import oskg_pkg::*;
(
  input wire logic aclk,
  output logic logic_reset_n,
  output logic pll_reset_n,
  output logic [1:0] profile_select,
  output logic bank_x_output_enable,
  output logic bank_y_output_enable,
  output logic global_output_enable,
  output logic [N_OUT-1:0] output_clock_gate
);
  initial begin
    logic_reset_n = 1'b1;
    pll_reset_n = 1'b1;
    profile_select = 2'h0;
    bank_x_output_enable = 1'b1;
    bank_y_output_enable = 1'b1;
    global_output_enable = 1'b1;
    output_clock_gate = 4'hf;
  end
  task prof_load(input logic [1:0] p);
    @(posedge aclk);
    logic_reset_n <= 1'b0;
    @(posedge aclk);
    profile_select <= p;
    // one spare cycle past the minimum hold
    repeat (LRST_CYC + 1) @(posedge aclk);
    logic_reset_n <= 1'b1;
  endtask : prof_load
  task pll_pulse(input int n);
    @(posedge aclk);
    pll_reset_n <= 1'b0;
    repeat (n) @(posedge aclk);
    pll_reset_n <= 1'b1;
  endtask : pll_pulse
  task set_oe(input logic x, input logic y, input logic g);
    @(posedge aclk);
    bank_x_output_enable <= x;
    bank_y_output_enable <= y;
    global_output_enable <= g;
  endtask : set_oe
  task set_gate(input logic [N_OUT-1:0] g);
    @(posedge aclk);
    output_clock_gate <= g;
    // slowest output period is 126 ticks
    repeat (3 * 128) @(posedge aclk);
  endtask : set_gate
endmodule : oskg_board

// ---- sim/test_output_skew_and_gating_control.sv ----
// testbench for the output skew and gating block
`timescale 1ns/1ps
module test_output_skew_and_gating_control
  import oskg_pkg::*;
;
  logic aclk = 1'b0, aresetn = 1'b0;
  logic lrst_n, prst_n, bx, by, ge;
  logic [1:0] psel, bresp, rresp, r;
  logic [N_OUT-1:0] gate, clk_out;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, d;
  logic [3:0] wstrb = 4'hf;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, pll_reset;
  int err_count = 0, samples_checked = 0, n;
  typedef struct {logic [1:0] p; logic x, y, g; logic [3:0] en;} oskg_row_t;
  oskg_row_t rows [4] = '{'{2'h0, 1, 1, 1, 4'hf}, '{2'h1, 1, 0, 1, 4'h3},
    '{2'h2, 0, 1, 1, 4'hc}, '{2'h3, 1, 1, 0, 4'h0}};
  always #2 aclk = ~aclk;
  oskg_board oskg_board_i (.aclk(aclk), .logic_reset_n(lrst_n), .pll_reset_n(prst_n),
    .profile_select(psel), .bank_x_output_enable(bx), .bank_y_output_enable(by),
    .global_output_enable(ge), .output_clock_gate(gate));
  oskg_top #(.PRST_CYCLES(16)) oskg_top_i (.aclk(aclk), .aresetn(aresetn),
    .logic_reset_n(lrst_n), .pll_reset_n(prst_n), .profile_select(psel),
    .bank_x_output_enable(bx), .bank_y_output_enable(by), .global_output_enable(ge),
    .output_clock_gate(gate), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .pll_reset(pll_reset), .clk_out(clk_out));
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task axi_wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rsp);
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    rsp = bresp;
    bready <= 1'b0;
  endtask : axi_wr
  task axi_rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rsp);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    v = rdata;
    rsp = rresp;
    rready <= 1'b0;
  endtask : axi_rd
  // ticks from a rise of output 0 to the next rise of output 1
  task skew_gap(output int k);
    k = 0;
    while (clk_out[0] !== 1'b0) @(posedge aclk);
    while (clk_out[0] !== 1'b1) @(posedge aclk);
    while (clk_out[1] !== 1'b1) begin
      @(posedge aclk);
      k++;
    end
  endtask : skew_gap
  task test_done;
    if (err_count == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : test_done
  initial begin
    #300000;
    err_count++;
    test_done();
  end
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    axi_rd(REG_SKEW, d, r);
    chk(d, SKEW_RST);
    axi_wr(REG_CTRL, 32'h0000_0008, r);
    chk({30'h0, r}, {30'h0, RESP_OKAY});
    foreach (rows[i]) begin
      oskg_board_i.prof_load(rows[i].p);
      oskg_board_i.set_oe(rows[i].x, rows[i].y, rows[i].g);
      repeat (OE_CYC + 1) @(posedge aclk);
      // outputs held off must stay low, so no stray edge escapes
      repeat (8) begin
        @(posedge aclk);
        chk({28'h0, clk_out & ~rows[i].en}, 32'h0);
      end
      axi_rd(REG_STAT, d, r);
      chk({30'h0, d[3:2]}, {30'h0, rows[i].p});
      chk({28'h0, d[7:4]}, {28'h0, rows[i].en});
      chk({30'h0, d[1:0]}, 32'h0);
      chk({31'h0, pll_reset}, 32'h0);
    end
    oskg_board_i.set_oe(1'b1, 1'b1, 1'b1);
    axi_wr(REG_SKEW, 32'hffff_ffff, r);
    axi_rd(REG_SKEW, d, r);
    chk(d, 32'h0000_ffff);
    // only byte 0 enabled: outputs 2 and 3 keep their setting
    wstrb <= 4'h1;
    axi_wr(REG_SKEW, 32'h0000_0000, r);
    wstrb <= 4'hf;
    axi_rd(REG_SKEW, d, r);
    chk(d, 32'h0000_ff00);
    axi_wr(8'h40, 32'h1, r);
    chk({30'h0, r}, {30'h0, RESP_SLVERR});
    axi_rd(8'h40, d, r);
    chk({d[29:0], r}, {30'h0, RESP_SLVERR});
    axi_wr(REG_SKEW, 32'h0000_00f0, r);
    axi_wr(REG_CTRL, 32'h0000_0080, r);
    oskg_board_i.set_gate(4'h0);
    oskg_board_i.set_gate(4'hf);
    skew_gap(n);
    chk(n, 32'd15);
    axi_wr(REG_CTRL, 32'h0000_0081, r);
    oskg_board_i.set_gate(4'h0);
    oskg_board_i.set_gate(4'hf);
    skew_gap(n);
    chk(n, 32'd30);
    oskg_board_i.pll_pulse(16);
    chk({31'h0, pll_reset}, 32'h1);
    repeat (20) @(posedge aclk);
    chk({31'h0, pll_reset}, 32'h0);
    test_done();
  end
endmodule : test_output_skew_and_gating_control
